// File: design/axr_pkg.sv
// Shared constants for the axis run status and zero point offset block
package axr_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_RUN_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h08;
  localparam logic [7:0] OFS_ZERO_OFS   = 8'h0C;
  localparam logic [7:0] OFS_ALARM_THR  = 8'h10;
  localparam logic [7:0] OFS_RANGE_NUM  = 8'h14;
  localparam logic [7:0] OFS_POS_MON    = 8'h18;
  localparam logic [7:0] OFS_RUN_MODE   = 8'h1C;

  // ****************************************
  // Status word fields
  // ****************************************
  localparam int unsigned ST_POSITION_ERROR_OVERFLOW = 0;
  localparam int unsigned ST_PRM   = 1;
  localparam int unsigned ST_FPRM  = 2;
  localparam int unsigned ST_TURN_COUNT_RECEIVE_ERROR  = 4;
  localparam int unsigned ST_READY = 7;

  // ****************************************
  // Run mode settings fields
  // ****************************************
  localparam int unsigned RM_POS    = 1;
  localparam int unsigned RM_PHASE  = 3;
  localparam int unsigned RM_ZRN    = 4;
  localparam int unsigned RM_CMD_EN = 8;
  localparam int unsigned RM_ABS_RD = 10;

  // ****************************************
  // Reset values and fixed figures
  // ****************************************
  localparam logic [31:0] RST_ZERO_OFS  = 32'h0000_0000;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [15:0] FIX_NUM_BIAS  = 16'h0064;
  localparam int unsigned SET_NUM_W     = 6;

endpackage

// File: design/axr_abs_if.sv
// Handshake between the status logic and the absolute position reader
`timescale 1ns/1ps
interface axr_abs_if;
  logic start;
  logic busy;
  logic done;
  logic fail;

  modport reader (
    input  start,
    output busy,
    output done,
    output fail
  );
  modport ctrl (
    output start,
    input  busy,
    input  done,
    input  fail
  );
endinterface

// File: design/axr_err_cmp.sv
// Position error magnitude check against the alarm threshold
`timescale 1ns/1ps
module axr_err_cmp
  import axr_pkg::*;
#(
  parameter int unsigned POS_W = 32,
  parameter int unsigned THR_W = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // Check inputs
  input  wire logic             enable,
  input  wire logic [POS_W-1:0] err_value,
  input  wire logic [THR_W-1:0] threshold,
  // Result
  output logic                  over
);

  typedef struct packed {
    logic over;
  } axr_cmp_type;

  axr_cmp_type r;
  axr_cmp_type n;
  logic [POS_W:0] mag;

  // One extra bit so the most negative error has a true magnitude
  always_comb begin
    n   = r;
    mag = err_value[POS_W-1] ? (POS_W+1)'(-{1'b1, err_value}) : {1'b0, err_value};
    n.over = enable && (mag > (POS_W+1)'(threshold)); // RQ4 RQ6
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign over = r.over;

  AST_POSITION_ERROR_OVERFLOW_SET: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ4
    (enable && (mag > (POS_W+1)'(threshold))) |=> over)
    else $error("overflow flag missed a large error");
  AST_POSITION_ERROR_OVERFLOW_MODE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ6
    (!enable) |=> !over)
    else $error("overflow flag raised outside a checked mode");

endmodule

// File: design/axr_abs_read.sv
// Absolute position read sequencer toward the encoder link
`timescale 1ns/1ps
module axr_abs_read
  import axr_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Control side
  axr_abs_if.reader link,
  // Encoder side
  output logic      enc_read_start,
  input  wire logic enc_read_done,
  input  wire logic enc_read_fail
);

  typedef enum logic [1:0] {ABS_IDLE, ABS_REQ, ABS_WAIT} axr_abs_state_type;

  typedef struct packed {
    axr_abs_state_type state;
    logic              start;
    logic              done;
    logic              fail;
  } axr_abs_type;

  axr_abs_type r;
  axr_abs_type n;

  always_comb begin
    n       = r;
    n.start = 1'b0;
    n.done  = 1'b0;
    case (r.state)
      ABS_IDLE: begin
        if (link.start) begin
          n.state = ABS_REQ;
          n.start = 1'b1;
        end
      end
      ABS_REQ: begin
        n.state = ABS_WAIT;
      end
      ABS_WAIT: begin
        // The reception result travels with the done pulse
        if (enc_read_done) begin
          n.state = ABS_IDLE;
          n.done  = 1'b1;
          n.fail  = enc_read_fail; // RQ10
        end
      end
      default: begin
        n.state = ABS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{state: ABS_IDLE, default: '0};
    end else begin
      r <= n;
    end
  end

  assign enc_read_start = r.start;
  assign link.busy      = (r.state != ABS_IDLE);
  assign link.done      = r.done;
  assign link.fail      = r.fail;

  sequence s_abs_go;
    link.start && (r.state == ABS_IDLE);
  endsequence
  sequence s_abs_req;
    enc_read_start && link.busy ##1 link.busy;
  endsequence
  AST_ABS_START: assert property (@(posedge sys_clk) disable iff (!arst_n) // RQ10
    s_abs_go |=> s_abs_req)
    else $error("read request did not reach the encoder");

endmodule

// File: design/axr_core.sv
// Axis run status, zero point offset and register slave
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// RQ1 - Monitor shows raw position plus signed offset
// RQ2 - Offset returns to zero at power-up
// RQ3 - Offset units: reference units if commands enabled
// RQ4 - Bit 0 set when error exceeds threshold
// RQ5 - Overflow flag never stops axis control
// RQ6 - Overflow checked only in position/zero/phase modes
// RQ7 - Bit 1 on setting error; number stored
// RQ8 - Bit 2 on fixed error; number plus 100
// RQ9 - Valid fixed write clears bit 2 itself
// RQ10 - Read encoder at power-up, on bit 10
// RQ11 - Bit 7 ready only when nothing blocks it
// RQ12 - Bits 3, 5, 6 always read zero
module axr_core
  import axr_pkg::*;
#(
  parameter int unsigned POS_W = 32,
  parameter int unsigned WRD_W = 16
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // Avalon-MM slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // Interrupt
  output logic                      irq,
  // Absolute encoder link
  output logic                      enc_read_start,
  input  wire logic                 enc_read_done,
  input  wire logic                 enc_read_fail,
  // Axis inputs
  input  wire logic [POS_W-1:0]     raw_position,
  input  wire logic [POS_W-1:0]     position_error_value,
  input  wire logic                 abs_encoder_sel,
  input  wire logic                 cmd_code_fixed_en,
  input  wire logic                 major_fault,
  input  wire logic                 unused_axis,
  input  wire logic                 fixed_params_changing,
  // Parameter checkers
  input  wire logic                 fixed_param_wr,
  input  wire logic                 fixed_param_bad,
  input  wire logic [WRD_W-1:0]     fixed_param_num,
  input  wire logic                 setting_range_bad,
  input  wire logic                 setting_err_strobe,
  input  wire logic [SET_NUM_W-1:0] setting_err_num,
  // Axis outputs
  output logic [WRD_W-1:0]          axis_run_status,
  output logic [POS_W-1:0]          position_monitor,
  output logic                      offset_in_ref_units
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic [POS_W-1:0] offset;
    logic [WRD_W-1:0] thr;
    logic [WRD_W-1:0] run_mode;
    logic [WRD_W-1:0] irq_st;
    logic [WRD_W-1:0] irq_mask;
    logic [WRD_W-1:0] range_num;
    logic             fprm;
    logic             turn_count_receive_error;
    logic [POS_W-1:0] monitor;
    logic [WRD_W-1:0] prev_st;
    logic             abs_prev;
    logic             pwr_pending;
    logic             prep_done;
    logic             start;
    logic             units;
    logic             first;
  } axr_core_type;

  localparam axr_core_type CORE_RST = '{
    offset:      RST_ZERO_OFS,
    thr:         RST_WORD,
    run_mode:    RST_WORD,
    irq_mask:    RST_WORD,
    pwr_pending: 1'b1,
    first:       1'b1,
    default:     '0
  };

  axr_core_type     r;
  axr_core_type     n;
  axr_abs_if        link ();
  logic             position_error_overflow;
  logic             position_error_overflow_en;
  logic             ready;
  logic             req;
  logic [WRD_W-1:0] status;
  logic [WRD_W-1:0] w1c;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] adr, input axr_core_type s,
                                          input logic [WRD_W-1:0] st);
    logic [31:0] v;
    v = '0;
    if (adr == OFS_RUN_STATUS) begin
      v = 32'(st);
    end else if (adr == OFS_IRQ_STATUS) begin
      v = 32'(s.irq_st);
    end else if (adr == OFS_IRQ_MASK) begin
      v = 32'(s.irq_mask);
    end else if (adr == OFS_ZERO_OFS) begin
      v = 32'(s.offset);
    end else if (adr == OFS_ALARM_THR) begin
      v = 32'(s.thr);
    end else if (adr == OFS_RANGE_NUM) begin
      v = 32'(s.range_num);
    end else if (adr == OFS_POS_MON) begin
      v = 32'(s.monitor);
    end else if (adr == OFS_RUN_MODE) begin
      v = 32'(s.run_mode);
    end
    return v;
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  assign position_error_overflow_en = r.run_mode[RM_POS] || r.run_mode[RM_ZRN] || r.run_mode[RM_PHASE]; // RQ6

  axr_err_cmp #(
    .POS_W (POS_W),
    .THR_W (WRD_W)
  ) u_cmp (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .enable    (position_error_overflow_en),
    .err_value (position_error_value),
    .threshold (r.thr),
    .over      (position_error_overflow)
  );

  axr_abs_read u_abs (
    .sys_clk        (sys_clk),
    .arst_n         (arst_n),
    .link           (link.reader),
    .enc_read_start (enc_read_start),
    .enc_read_done  (enc_read_done),
    .enc_read_fail  (enc_read_fail)
  );

  assign link.start = r.start;

  // ****************************************
  // Status word
  // ****************************************
  // Ready deliberately ignores the overflow flag: control goes on
  assign ready = r.prep_done && !major_fault && !unused_axis && !r.fprm && !r.turn_count_receive_error // RQ11 RQ5
                 && !fixed_params_changing && !link.busy && !r.start;

  always_comb begin
    status           = '0; // RQ12
    status[ST_POSITION_ERROR_OVERFLOW] = position_error_overflow; // RQ4
    status[ST_PRM]   = setting_range_bad; // RQ7
    status[ST_FPRM]  = r.fprm; // RQ8
    status[ST_TURN_COUNT_RECEIVE_ERROR]  = r.turn_count_receive_error; // RQ10
    status[ST_READY] = ready; // RQ11
  end

  assign req = avs_read || avs_write;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n           = r;
    w1c         = '0;
    n.first     = 1'b0;
    n.ack       = req && !r.ack;
    n.monitor   = POS_W'(raw_position + r.offset); // RQ1
    n.units     = cmd_code_fixed_en && r.run_mode[RM_CMD_EN]; // RQ3
    n.prev_st   = status;
    n.abs_prev  = r.run_mode[RM_ABS_RD];
    // Read data is captured in the wait cycle so it comes from a flip-flop
    if (req && !r.ack) begin
      n.rdata = rd_mux(avs_address, r, status);
    end
    if (avs_write && r.ack) begin
      if (avs_address == OFS_IRQ_STATUS) begin
        w1c = WRD_W'(wmerge('0, avs_writedata, avs_byteenable));
      end else if (avs_address == OFS_IRQ_MASK) begin
        n.irq_mask = WRD_W'(wmerge(32'(r.irq_mask), avs_writedata, avs_byteenable));
      end else if (avs_address == OFS_ZERO_OFS) begin
        n.offset = POS_W'(wmerge(32'(r.offset), avs_writedata, avs_byteenable));
      end else if (avs_address == OFS_ALARM_THR) begin
        n.thr = WRD_W'(wmerge(32'(r.thr), avs_writedata, avs_byteenable));
      end else if (avs_address == OFS_RUN_MODE) begin
        n.run_mode = WRD_W'(wmerge(32'(r.run_mode), avs_writedata, avs_byteenable));
      end
    end
    // New rising status bits win over a clear in the same cycle
    n.irq_st = (r.irq_st & ~w1c) | (status & ~r.prev_st);
    // Setting range errors keep the latest offending number
    if (setting_err_strobe) begin
      n.range_num = WRD_W'(setting_err_num); // RQ7
    end
    // A fixed parameter error number takes priority over a setting number
    if (fixed_param_wr) begin
      if (fixed_param_bad) begin
        n.fprm      = 1'b1; // RQ8
        n.range_num = WRD_W'(fixed_param_num + FIX_NUM_BIAS); // RQ8
      end else begin
        n.fprm = 1'b0; // RQ9
      end
    end
    // Power-up read and later reads on a rising request bit
    n.start = 1'b0;
    if (abs_encoder_sel && !link.busy && !r.start
        && (r.pwr_pending || (r.run_mode[RM_ABS_RD] && !r.abs_prev))) begin
      n.start = 1'b1; // RQ10
      n.turn_count_receive_error  = 1'b0;
    end
    n.pwr_pending = 1'b0;
    if (link.done && link.fail) begin
      n.turn_count_receive_error = 1'b1; // RQ10
    end
    if (!r.pwr_pending && !r.start && !link.busy) begin
      n.prep_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= CORE_RST; // RQ2
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_waitrequest     = req && !r.ack;
  assign avs_readdata        = r.rdata;
  assign irq                 = |(r.irq_st & r.irq_mask);
  assign axis_run_status     = status;
  assign position_monitor    = r.monitor;
  assign offset_in_ref_units = r.units;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_MONITOR_SUM: assert property (!r.first |-> // RQ1
    position_monitor == POS_W'($past(raw_position) + $past(r.offset)))
    else $error("position monitor is not raw plus offset");

  AST_OFFSET_ZERO: assert property (r.first |-> r.offset == RST_ZERO_OFS) // RQ2
    else $error("offset not zero after power-up");

  AST_UNITS: assert property (!r.first |-> // RQ3
    offset_in_ref_units == ($past(cmd_code_fixed_en) && $past(r.run_mode[RM_CMD_EN])))
    else $error("offset unit select wrong");

  AST_POSITION_ERROR_OVERFLOW_NOSTOP: assert property ((position_error_overflow && r.prep_done && !major_fault && !unused_axis // RQ5
    && !r.fprm && !r.turn_count_receive_error && !fixed_params_changing && !link.busy && !r.start) |-> ready)
    else $error("overflow flag blocked readiness");

  AST_PRM_NUM: assert property ((setting_err_strobe && !fixed_param_wr) |=> // RQ7
    r.range_num == WRD_W'($past(setting_err_num)))
    else $error("setting error number not stored");

  AST_FPRM_NUM: assert property ((fixed_param_wr && fixed_param_bad) |=> // RQ8
    r.fprm && (r.range_num == WRD_W'($past(fixed_param_num) + FIX_NUM_BIAS)))
    else $error("fixed error flag or number wrong");

  AST_FPRM_CLEAR: assert property ((fixed_param_wr && !fixed_param_bad) |=> !r.fprm) // RQ9
    else $error("valid fixed write did not clear flag");

  AST_TURN_COUNT_RECEIVE_ERROR: assert property ((link.done && link.fail) |=> axis_run_status[ST_TURN_COUNT_RECEIVE_ERROR]) // RQ10
    else $error("receive error not flagged");

  AST_READY_BLOCK: assert property (axis_run_status[ST_READY] |-> // RQ11
    !(major_fault || unused_axis || r.fprm || r.turn_count_receive_error || fixed_params_changing || link.busy))
    else $error("ready high while blocked");

  AST_UNUSED_BITS: assert property (axis_run_status[3] == 1'b0 && axis_run_status[5] == 1'b0 // RQ12
    && axis_run_status[6] == 1'b0)
    else $error("unused status bit set");

  AST_BUS_ANSWER: assert property ((req && avs_waitrequest) |=> !avs_waitrequest) // RQ1
    else $error("bus answer late");

  AST_RDATA_HOLD: assert property (!(req && !r.ack) |=> $stable(avs_readdata)) // RQ1
    else $error("read data moved outside a capture");

  AST_OFFSET_HOLD: assert property (!(avs_write && r.ack && (avs_address == OFS_ZERO_OFS)) |=> // RQ2
    $stable(r.offset))
    else $error("offset changed without a write");

  // A new event must survive a clear written in the same cycle
  AST_IRQ_SET_WINS: assert property ((|(status & ~r.prev_st)) |=> // RQ4
    ((r.irq_st & $past(status & ~r.prev_st)) == $past(status & ~r.prev_st)))
    else $error("status event lost");

  AST_POWERUP_READ: assert property ((r.first && abs_encoder_sel) |=> link.start) // RQ10
    else $error("no encoder read after power-up");

  AST_READ_ON_RISE: assert property (($rose(r.run_mode[RM_ABS_RD]) && abs_encoder_sel // RQ10
    && !link.busy && !r.start) |=> link.start)
    else $error("read request bit did not start a read");

  // A failed read has to show as an error and take ready away
  sequence s_read_failed;
    link.done && link.fail;
  endsequence
  sequence s_fail_shown;
    axis_run_status[ST_TURN_COUNT_RECEIVE_ERROR] && !axis_run_status[ST_READY];
  endsequence
  AST_TURN_COUNT_RECEIVE_ERROR_HOLDS_READY: assert property (s_read_failed |=> s_fail_shown) // RQ10 RQ11
    else $error("failed read left ready high");

endmodule

// File: dv/axr_enc_model.sv
// Behavioural absolute encoder link answering position read requests
`timescale 1ns/1ps
module axr_enc_model #(
  parameter int unsigned DLY = 8
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Link
  input  wire logic enc_read_start,
  input  wire logic fail_next,
  output logic      enc_read_done,
  output logic      enc_read_fail
);
  int unsigned cnt;
  logic        noise;

  // Fail only means something beside done, so it wanders in between
  assign enc_read_fail = enc_read_done ? fail_next : noise;

  // DLY of at least 2 keeps done clear of the start pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt           <= 0;
      enc_read_done <= 1'b0;
      noise         <= 1'b0;
    end else begin
      noise         <= ~noise;
      enc_read_done <= (cnt == 1);
      if (enc_read_start) begin
        cnt <= DLY;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: dv/tb_axr_core.sv
// Self-checking bench for the axis run status and offset block
`timescale 1ns/1ps
module tb_axr_core;
  import axr_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        sys_clk;
  logic        arst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        enc_read_start;
  logic        enc_read_done;
  logic        enc_read_fail;
  logic        fail_next;
  logic [31:0] raw_position;
  logic [31:0] err_val;
  logic        abs_sel;
  logic        cmd_en;
  logic [2:0]  blk;
  logic        fix_wr;
  logic        fix_bad;
  logic [15:0] fix_num;
  logic        set_bad;
  logic        set_stb;
  logic [5:0]  set_num;
  logic [15:0] run_status;
  logic [31:0] pos_mon;
  logic        ref_units;
  int          fails;
  int          checked;
  logic [31:0] modes [4];

  axr_core i_axr_core (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .enc_read_start(enc_read_start), .enc_read_done(enc_read_done), .enc_read_fail(enc_read_fail),
    .raw_position(raw_position), .position_error_value(err_val), .abs_encoder_sel(abs_sel),
    .cmd_code_fixed_en(cmd_en), .major_fault(blk[0]), .unused_axis(blk[1]),
    .fixed_params_changing(blk[2]), .fixed_param_wr(fix_wr), .fixed_param_bad(fix_bad),
    .fixed_param_num(fix_num), .setting_range_bad(set_bad), .setting_err_strobe(set_stb),
    .setting_err_num(set_num), .axis_run_status(run_status), .position_monitor(pos_mon),
    .offset_in_ref_units(ref_units));

  axr_enc_model #(.DLY(8)) i_axr_enc_model (
    .sys_clk(sys_clk), .arst_n(arst_n), .enc_read_start(enc_read_start), .fail_next(fail_next),
    .enc_read_done(enc_read_done), .enc_read_fail(enc_read_fail));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pins are looked at mid-cycle, where they have settled
  task automatic chk_pin(input logic [31:0] got_dummy, input logic exp, input int sel);
    logic g;
    @(negedge sys_clk);
    g = (sel == 0) ? irq : (sel == 1) ? ref_units : (pos_mon === got_dummy);
    chk_word({31'h0, g}, {31'h0, exp});
    @(posedge sys_clk);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    int   n;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= 4'hF;
    avs_read       <= !wr;
    avs_write      <= wr;
    n = 0;
    w = 1'b1;
    q = 32'h0;
    // Waitrequest and read data are both taken at the same rising edge
    while (w !== 1'b0) begin
      @(posedge sys_clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
      if (n > 50) begin
        fails++;
        end_of_test();
      end
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk_word(x, e);
  endtask

  // Encoder reads take a while, so the status word is polled
  task automatic wait_stat(input logic [31:0] e);
    logic [31:0] x;
    int          n;
    n = 0;
    x = 32'h0;
    bus(1'b0, OFS_RUN_STATUS, 32'h0, x);
    while (x !== e && n < 40) begin
      bus(1'b0, OFS_RUN_STATUS, 32'h0, x);
      n++;
    end
    chk_word(x, e);
  endtask

  task automatic fix_pulse(input logic bad);
    fix_bad <= bad;
    fix_wr  <= 1'b1;
    @(posedge sys_clk);
    fix_wr  <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fails = 0;
    checked = 0;
    modes = '{32'h0000_0004, 32'h1 << RM_POS, 32'h1 << RM_PHASE, 32'h1 << RM_ZRN};
    arst_n <= 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= '0;
    {raw_position, err_val, cmd_en, blk, fix_wr, fix_bad, fix_num} <= '0;
    {set_bad, set_stb, set_num, fail_next} <= '0;
    abs_sel <= 1'b1;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (modes[i]) begin
      rd(i == 0 ? OFS_ZERO_OFS : i == 1 ? OFS_ALARM_THR : i == 2 ? OFS_IRQ_MASK : OFS_RUN_MODE, 32'h0);
    end
    rd(OFS_RANGE_NUM, 32'h0);
    rd(8'h20, 32'h0);
    wait_stat(32'h0000_0080);
    wr(OFS_RUN_STATUS, 32'hFFFF_FFFF);
    rd(OFS_RUN_STATUS, 32'h0000_0080);
    @(negedge sys_clk);
    chk_word({16'h0, run_status}, 32'h0000_0080);
    @(posedge sys_clk);
    raw_position <= 32'd120;
    wr(OFS_ZERO_OFS, 32'hFFFF_FF88);
    rd(OFS_ZERO_OFS, 32'hFFFF_FF88);
    rd(OFS_POS_MON, 32'h0);
    chk_pin(32'h0, 1'b1, 2);
    for (int i = 0; i < 4; i++) begin
      cmd_en <= i[0];
      wr(OFS_RUN_MODE, {23'h0, i[1], 8'h0});
      chk_pin(32'h0, i == 3, 1);
    end
    wr(OFS_ALARM_THR, 32'd100);
    err_val <= 32'd101;
    foreach (modes[i]) begin
      wr(OFS_RUN_MODE, modes[i]);
      rd(OFS_RUN_STATUS, i == 0 ? 32'h0000_0080 : 32'h0000_0081);
    end
    // The overflow flag is registered, so a new error needs one cycle to land
    err_val <= 32'd100;
    @(posedge sys_clk);
    rd(OFS_RUN_STATUS, 32'h0000_0080);
    err_val <= 32'hFFFF_FF9B;
    @(posedge sys_clk);
    rd(OFS_RUN_STATUS, 32'h0000_0081);
    wr(OFS_IRQ_STATUS, 32'hFFFF_FFFF);
    rd(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    err_val <= 32'h0;
    @(posedge sys_clk);
    rd(OFS_RUN_STATUS, 32'h0000_0080);
    // Event bit lands one cycle after the flag itself
    err_val <= 32'hFFFF_FF9B;
    repeat (2) @(posedge sys_clk);
    rd(OFS_IRQ_STATUS, 32'h1);
    chk_pin(32'h0, 1'b1, 0);
    wr(OFS_IRQ_MASK, 32'h0);
    chk_pin(32'h0, 1'b0, 0);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    chk_pin(32'h0, 1'b0, 0);
    err_val <= 32'h0;
    set_bad <= 1'b1;
    set_num <= 6'h3F;
    set_stb <= 1'b1;
    @(posedge sys_clk);
    set_stb <= 1'b0;
    rd(OFS_RUN_STATUS, 32'h0000_0082);
    rd(OFS_RANGE_NUM, 32'h0000_003F);
    set_bad <= 1'b0;
    fix_num <= 16'h0005;
    fix_pulse(1'b1);
    rd(OFS_RUN_STATUS, 32'h0000_0004);
    rd(OFS_RANGE_NUM, 32'h0000_0069);
    fix_pulse(1'b0);
    rd(OFS_RUN_STATUS, 32'h0000_0080);
    for (int i = 0; i < 3; i++) begin
      blk <= 3'h1 << i;
      rd(OFS_RUN_STATUS, 32'h0);
      blk <= 3'h0;
      rd(OFS_RUN_STATUS, 32'h0000_0080);
    end
    fail_next <= 1'b1;
    wr(OFS_RUN_MODE, 32'h1 << RM_ABS_RD);
    rd(OFS_RUN_STATUS, 32'h0);
    wait_stat(32'h0000_0010);
    wr(OFS_RUN_MODE, 32'h0);
    fail_next <= 1'b0;
    wr(OFS_RUN_MODE, 32'h1 << RM_ABS_RD);
    wait_stat(32'h0000_0080);
    // Power cycle mid-run: the offset has to come back as zero
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_ZERO_OFS, 32'h0);
    chk_pin(32'd120, 1'b1, 2);
    end_of_test();
  end
endmodule
